// ---- mfc_mac_ctrl.sv ----
// Purpose: MAC control register bits, collision back-off and receive filtering.
// Assumes: AHB-Lite slave with zero wait states; one collision pulse per attempt.
// Notes: Registered read data; interrupt follows status by one cycle.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mfc_mac_ctrl (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic i_tx_start,
  input wire logic i_tx_collision,
  input wire logic i_tx_done,
  output logic o_tx_go,
  output logic o_tx_abort,
  output logic o_retry_error,
  input mfc_pkg::mfc_byte_t i_rx_byte,
  output mfc_pkg::mfc_byte_t o_rx_byte,
  output logic o_irq
);
  import mfc_pkg::*;

  // ==========================================================================
  // Bus slave
  // The slave never inserts wait states: hready is low only through reset.
  // Write data follow their address by one cycle, so the write is held pending.
  // Read data are latched at the address phase, which is why a read in the data
  // phase of a write to the same register still sees the old value.

  logic hready_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [4:0] wr_addr_ff;
  logic addr_phase;
  logic [4:0] rd_addr;
  logic [31:0] rd_mux;
  logic wr_cr;
  logic wr_cfg;
  logic wr_sts;
  logic wr_en;

  logic [31:0] cr_ff;
  logic cfg_speed_ff;
  logic [NUM_EVT-1:0] sts_ff;
  logic [NUM_EVT-1:0] nxt_sts;
  logic [NUM_EVT-1:0] en_ff;
  logic [NUM_EVT-1:0] evt;
  logic irq_ff;

  assign addr_phase = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  assign rd_addr = i_haddr[4:0];
  assign wr_cr = wr_pend_ff && (wr_addr_ff == REG_MAC_CR);
  assign wr_cfg = wr_pend_ff && (wr_addr_ff == REG_LINK_CFG);
  assign wr_sts = wr_pend_ff && (wr_addr_ff == REG_INT_STS);
  assign wr_en = wr_pend_ff && (wr_addr_ff == REG_INT_EN);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hready_ff <= 1'b0;
      hrdata_ff <= '0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      hready_ff <= 1'b1;
      // Narrow writes and writes above the map are dropped rather than merged.
      wr_pend_ff <= addr_phase && i_hwrite && (i_hsize == HSIZE_WORD) && (i_haddr[31:5] == '0);
      wr_addr_ff <= rd_addr;
      if (addr_phase && !i_hwrite) begin
        hrdata_ff <= (i_haddr[31:5] == '0) ? rd_mux : 32'h0000_0000;
      end
    end
  end

  assign o_hreadyout = hready_ff;
  assign o_hrdata = hrdata_ff;
  assign o_hresp = 1'b0;

  // ==========================================================================
  // Control, status and interrupt registers
  // Bits of the control word outside its fields are masked on write, so they
  // read back as zero and cannot steer any logic.

  logic broadcast_frame_ctrl_block;
  logic retry_dis;
  logic pad_en;
  logic [1:0] bo_limit;

  assign broadcast_frame_ctrl_block = cr_ff[CR_BROADCAST_FRAME_CTRL_BIT];
  assign retry_dis = cr_ff[CR_RETRY_DIS_BIT];
  assign pad_en = cr_ff[CR_PAD_BIT];
  assign bo_limit = cr_ff[CR_BOLIM_LSB +: 2];

  // A set in the same cycle as a write-one-to-clear keeps the bit set.
  assign nxt_sts = (sts_ff & ~(wr_sts ? i_hwdata[NUM_EVT-1:0] : '0)) | evt;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cr_ff <= CR_RESET;
      cfg_speed_ff <= 1'b0;
      sts_ff <= '0;
      en_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_cr) begin
        cr_ff <= i_hwdata & CR_WMASK;
      end
      if (wr_cfg) begin
        cfg_speed_ff <= i_hwdata[CFG_SPEED100_BIT];
      end
      if (wr_en) begin
        en_ff <= i_hwdata[NUM_EVT-1:0];
      end
      sts_ff <= nxt_sts;
      irq_ff <= |(sts_ff & en_ff);
    end
  end

  assign o_irq = irq_ff;

  // ==========================================================================
  // Random source
  // The register runs from reset on, so the value drawn depends on the cycle
  // in which the collision falls.

  logic [LFSR_W-1:0] lfsr_val;

  mfc_lfsr #(
    .WIDTH(LFSR_W)
  ) u_lfsr (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_value(lfsr_val)
  );

  // ==========================================================================
  // Transmit attempt and back-off sequencer
  // A collision either abandons the frame or loads a random slot count; the
  // count runs down once per slot time and reaching zero sends the next
  // attempt. A draw of zero retries at once, without entering the wait.
  // The slot is rounded up to whole clock cycles, so at 100 Mb/s it lasts a
  // little longer than 512 bit times.

  localparam logic [10:0] SLOT_10M = 11'(SLOT_CYC_10M);
  localparam logic [10:0] SLOT_100M = 11'(SLOT_CYC_100M);

  mfc_tx_state_t state_ff;
  mfc_tx_state_t nxt_state;
  logic [4:0] coll_ff;
  logic [4:0] nxt_coll;
  logic [9:0] bo_cnt_ff;
  logic [9:0] nxt_bo_cnt;
  logic [10:0] slot_ff;
  logic [10:0] nxt_slot;
  logic go_ff;
  logic nxt_go;
  logic abort_ff;
  logic nxt_abort;
  logic [10:0] slot_len;
  logic [4:0] coll_inc;
  logic [3:0] k_exp;
  logic [3:0] lim_bits;
  logic [3:0] use_bits;
  logic [9:0] draw_mask;
  logic [9:0] draw;
  logic give_up;

  assign slot_len = cfg_speed_ff ? SLOT_100M : SLOT_10M;
  assign coll_inc = coll_ff + 5'h01;
  assign k_exp = (coll_inc > 5'(MAX_K)) ? 4'(MAX_K) : coll_inc[3:0];
  assign lim_bits = mfc_limit_bits(bo_limit);
  assign use_bits = (k_exp < lim_bits) ? k_exp : lim_bits;
  assign draw_mask = 10'((11'h001 << use_bits) - 11'h001);
  assign draw = lfsr_val[9:0] & draw_mask;
  // The sixteenth collision ends a frame; with retry disabled, the first does.
  assign give_up = retry_dis || (coll_inc == MAX_ATTEMPTS);

  always_comb begin
    nxt_state = state_ff;
    nxt_coll = coll_ff;
    nxt_bo_cnt = bo_cnt_ff;
    nxt_slot = slot_ff;
    nxt_go = 1'b0;
    nxt_abort = 1'b0;
    case (state_ff)
      TX_IDLE: begin
        if (i_tx_start) begin
          nxt_state = TX_SEND;
          nxt_coll = 5'h00;
          nxt_go = 1'b1;
        end
      end

      TX_SEND: begin
        // A collision is taken before a done in the same cycle.
        if (i_tx_collision) begin
          nxt_coll = coll_inc;
          if (give_up) begin
            nxt_state = TX_IDLE;
            nxt_abort = 1'b1;
          end else if (draw == 10'h000) begin
            nxt_go = 1'b1;
          end else begin
            nxt_state = TX_WAIT;
            nxt_bo_cnt = draw;
            nxt_slot = slot_len - 11'h001;
          end
        end else if (i_tx_done) begin
          nxt_state = TX_IDLE;
        end
      end

      TX_WAIT: begin
        // The count was loaded nonzero, so a count of one here ends the wait.
        if (slot_ff == 11'h000) begin
          nxt_slot = slot_len - 11'h001;
          nxt_bo_cnt = bo_cnt_ff - 10'h001;
          if (bo_cnt_ff == 10'h001) begin
            nxt_state = TX_SEND;
            nxt_go = 1'b1;
          end
        end else begin
          nxt_slot = slot_ff - 11'h001;
        end
      end

      default: begin
        nxt_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= TX_IDLE;
      coll_ff <= '0;
      bo_cnt_ff <= '0;
      slot_ff <= '0;
      go_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      coll_ff <= nxt_coll;
      bo_cnt_ff <= nxt_bo_cnt;
      slot_ff <= nxt_slot;
      go_ff <= nxt_go;
      abort_ff <= nxt_abort;
    end
  end

  assign o_tx_go = go_ff;
  assign o_tx_abort = abort_ff;
  assign o_retry_error = abort_ff;

  // ==========================================================================
  // Receive path
  // The control bits are taken when a frame's first byte leaves the delay, so
  // a change in mid-frame applies from the next frame on.
  logic rx_bdrop;
  logic rx_pstrip;

  mfc_rx_strip u_rx (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_broadcast_frame_ctrl_block(broadcast_frame_ctrl_block),
    .i_pad_en(pad_en),
    .i_byte(i_rx_byte),
    .o_byte(o_rx_byte),
    .o_broadcast_frame_ctrl_drop(rx_bdrop),
    .o_pad_strip(rx_pstrip)
  );

  // ==========================================================================
  // Events and read mux
  // Every event is a one-cycle pulse; the status register makes it sticky.
  always_comb begin
    evt = '0;
    evt[EVT_TX_DONE] = (state_ff == TX_SEND) && i_tx_done && !i_tx_collision;
    evt[EVT_COLL] = (state_ff == TX_SEND) && i_tx_collision;
    evt[EVT_RETRY_ERR] = abort_ff;
    evt[EVT_BROADCAST_FRAME_CTRL_DROP] = rx_bdrop;
    evt[EVT_PAD_STRIP] = rx_pstrip;
  end

  logic [31:0] bo_sts;

  assign bo_sts = (32'(coll_ff) << BO_COLL_LSB) | (32'(state_ff) << BO_STATE_LSB)
                | (32'(bo_cnt_ff) << BO_CNT_LSB);

  // Offsets without a register read as zero.
  assign rd_mux = (rd_addr == REG_MAC_CR) ? cr_ff
                : (rd_addr == REG_LINK_CFG) ? 32'(cfg_speed_ff)
                : (rd_addr == REG_INT_STS) ? 32'(sts_ff)
                : (rd_addr == REG_INT_EN) ? 32'(en_ff)
                : (rd_addr == REG_BO_STS) ? bo_sts
                : 32'h0000_0000;
endmodule : mfc_mac_ctrl

// ---- mfc_pkg.sv ----
// Purpose: Shared constants and types for the MAC frame control and back-off block.
// Assumes: 20 MHz clock, AHB-Lite register access with 32-bit words.
// Notes: Time figures are kept in their own units; cycle counts derive from them.
// Contract
// - Broadcast control bit 11 gates broadcast delivery.
// - Retry-disable bit 10 abandons frame on collision.
// - Pad strip bit 8 removes pad below 46.
// - Stripping pad also strips the frame FCS.
// - Length 46 or more passes unchanged with FCS.
// - Pad strip off forwards frames unmodified.
// - Wait random r slots, 0 <= r < 2^K.
// - K is min(retry count, 10).
// - Random value from free-running 20-bit LFSR.
// - Load LFSR bits, count down per slot.
// - Back-off limit bits 7-6 cap LFSR bits.
// - Limit codes 00/01/10/11 give 10/8/4/1 bits.
package mfc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [4:0] REG_MAC_CR = 5'h00;
  localparam logic [4:0] REG_LINK_CFG = 5'h04;
  localparam logic [4:0] REG_INT_STS = 5'h08;
  localparam logic [4:0] REG_INT_EN = 5'h0c;
  localparam logic [4:0] REG_BO_STS = 5'h10;
  localparam int unsigned CR_BROADCAST_FRAME_CTRL_BIT = 11;
  localparam int unsigned CR_RETRY_DIS_BIT = 10;
  localparam int unsigned CR_PAD_BIT = 8;
  localparam int unsigned CR_BOLIM_LSB = 6;
  localparam logic [31:0] CR_WMASK = 32'h0000_0dc0;
  localparam logic [31:0] CR_RESET = 32'h0000_0000;
  localparam int unsigned CFG_SPEED100_BIT = 0;
  localparam int unsigned NUM_EVT = 5;
  localparam int unsigned EVT_TX_DONE = 0;
  localparam int unsigned EVT_COLL = 1;
  localparam int unsigned EVT_RETRY_ERR = 2;
  localparam int unsigned EVT_BROADCAST_FRAME_CTRL_DROP = 3;
  localparam int unsigned EVT_PAD_STRIP = 4;
  localparam int unsigned BO_COLL_LSB = 0;
  localparam int unsigned BO_STATE_LSB = 8;
  localparam int unsigned BO_CNT_LSB = 16;
  // ==========================================================================
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ==========================================================================
  // Frame layout
  localparam int unsigned DA_LEN = 6;
  localparam int unsigned HDR_LEN = 14;
  localparam int unsigned LEN_HI_IDX = 12;
  localparam int unsigned LEN_LO_IDX = 13;
  localparam logic [15:0] MIN_DATA_LEN = 16'h002e;
  localparam logic [7:0] BROADCAST_FRAME_CTRL_BYTE = 8'hff;
  // ==========================================================================
  // Back-off
  localparam int unsigned LFSR_W = 20;
  localparam logic [19:0] LFSR_SEED = 20'h00001;
  localparam int unsigned MAX_K = 10;
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam int unsigned SLOT_BITS = 512;
  localparam int unsigned BIT_NS_10M = 100;
  localparam int unsigned BIT_NS_100M = 10;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned SLOT_CYC_10M = (SLOT_BITS * BIT_NS_10M + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLOT_CYC_100M = (SLOT_BITS * BIT_NS_100M + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_WAIT = 2'b10
  } mfc_tx_state_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } mfc_byte_t;

  function automatic logic [3:0] mfc_limit_bits(input logic [1:0] code);
    case (code)
      2'b00: mfc_limit_bits = 4'ha;
      2'b01: mfc_limit_bits = 4'h8;
      2'b10: mfc_limit_bits = 4'h4;
      default: mfc_limit_bits = 4'h1;
    endcase
  endfunction : mfc_limit_bits
endpackage : mfc_pkg

// ---- mfc_lfsr.sv ----
// Purpose: Free-running pseudo-random source for collision back-off.
// Assumes: Polynomial x^20 + x^17 + 1, maximal length for 20 bits.
// Notes: The register never holds zero because the seed is nonzero.
`timescale 1ns/1ps
module mfc_lfsr #(
  parameter int unsigned WIDTH = mfc_pkg::LFSR_W
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  output logic [WIDTH-1:0] o_value
);
  import mfc_pkg::*;

  // The tap positions are fixed for the documented width only.
  if (WIDTH != LFSR_W) begin : g_bad_width
    $error("mfc_lfsr supports only a 20-bit register");
  end

  logic [WIDTH-1:0] lfsr_ff;
  logic [WIDTH-1:0] nxt_lfsr;

  assign nxt_lfsr = {lfsr_ff[WIDTH-2:0], lfsr_ff[WIDTH-1] ^ lfsr_ff[16]};
  assign o_value = lfsr_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lfsr_ff <= LFSR_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end
endmodule : mfc_lfsr

// ---- mfc_rx_strip.sv ----
// Purpose: Receive path with broadcast rejection and automatic pad stripping.
// Assumes: Bytes of one frame arrive on consecutive cycles.
// Notes: A fixed six-cycle delay lets the whole destination address be seen
//   before its first byte leaves; frames of at least six bytes need no idle cycles between them.
`timescale 1ns/1ps
module mfc_rx_strip (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_broadcast_frame_ctrl_block,
  input wire logic i_pad_en,
  input mfc_pkg::mfc_byte_t i_byte,
  output mfc_pkg::mfc_byte_t o_byte,
  output logic o_broadcast_frame_ctrl_drop,
  output logic o_pad_strip
);
  import mfc_pkg::*;

  mfc_byte_t pipe_ff [DA_LEN];
  mfc_byte_t out_ff;
  logic [10:0] in_idx_ff;
  logic [10:0] out_idx_ff;
  logic is_bc_ff;
  logic drop_ff;
  logic pad_en_ff;
  logic bdrop_ff;
  logic pstrip_ff;
  logic [15:0] len_ff;
  mfc_byte_t head;
  logic first_out;
  logic drop_now;
  logic pad_en_now;
  logic pad_now;
  logic [10:0] end_idx;
  logic at_end;
  logic past_end;

  assign head = pipe_ff[DA_LEN-1];
  assign first_out = head.valid && (out_idx_ff == 11'h000);
  assign drop_now = first_out ? (is_bc_ff && i_broadcast_frame_ctrl_block) : drop_ff;
  assign pad_en_now = first_out ? i_pad_en : pad_en_ff;
  assign pad_now = pad_en_now && (len_ff < MIN_DATA_LEN);
  assign end_idx = 11'(HDR_LEN) + len_ff[10:0];
  assign at_end = pad_now && (out_idx_ff + 11'h001 == end_idx);
  assign past_end = pad_now && (out_idx_ff >= end_idx);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < DA_LEN; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      pipe_ff[0] <= i_byte;
      for (int i = 1; i < DA_LEN; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  // ==========================================================================
  // Input side: destination and length capture
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      in_idx_ff <= '0;
      is_bc_ff <= 1'b0;
      len_ff <= '0;
    end else if (i_byte.valid) begin
      in_idx_ff <= i_byte.last ? 11'h000 : in_idx_ff + {10'h000, ~&in_idx_ff};
      if (in_idx_ff < 11'(DA_LEN)) begin
        is_bc_ff <= (in_idx_ff == 11'h000 || is_bc_ff) && (i_byte.data == BROADCAST_FRAME_CTRL_BYTE);
      end
      if (in_idx_ff == 11'(LEN_HI_IDX)) begin
        len_ff[15:8] <= i_byte.data;
      end
      if (in_idx_ff == 11'(LEN_LO_IDX)) begin
        len_ff[7:0] <= i_byte.data;
      end
    end
  end

  // ==========================================================================
  // Output side
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_idx_ff <= '0;
      drop_ff <= 1'b0;
      pad_en_ff <= 1'b0;
      out_ff <= '0;
      bdrop_ff <= 1'b0;
      pstrip_ff <= 1'b0;
    end else begin
      if (head.valid) begin
        out_idx_ff <= head.last ? 11'h000 : out_idx_ff + {10'h000, ~&out_idx_ff};
      end
      if (first_out) begin
        drop_ff <= drop_now;
        pad_en_ff <= i_pad_en;
      end
      out_ff.valid <= head.valid && !drop_now && !past_end;
      out_ff.last <= head.last || at_end;
      out_ff.data <= head.data;
      bdrop_ff <= first_out && drop_now;
      pstrip_ff <= head.valid && at_end && !drop_now;
    end
  end

  assign o_byte = out_ff;
  assign o_broadcast_frame_ctrl_drop = bdrop_ff;
  assign o_pad_strip = pstrip_ff;
endmodule : mfc_rx_strip

// ---- mfc_mac_ctrl_properties.sv ----
// Purpose: Port-level checks of the MAC control block.
// Assumes: A shadow of the control word is rebuilt from observed bus writes.
// Notes: Collisions count only while an attempt is known to be on the wire.
`timescale 1ns/1ps
module mfc_mac_ctrl_properties (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_tx_collision,
  input wire logic i_tx_done,
  input wire logic o_tx_go,
  input wire logic o_tx_abort,
  input wire logic o_retry_error,
  input mfc_pkg::mfc_byte_t i_rx_byte,
  input mfc_pkg::mfc_byte_t o_rx_byte
);
  import mfc_pkg::*;
  // ==========================================================================
  // Shadow state
  logic wr_ph_ff;
  logic snd_ff;
  logic [11:0] cr_ff;
  logic [10:0] lim_wait_ff;
  localparam int unsigned LIM_WAIT = SLOT_CYC_10M + 1;
  wire cr_hit = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && i_hwrite &&
    i_hsize == HSIZE_WORD && i_haddr == 32'(REG_MAC_CR);
  wire coll_v = snd_ff && i_tx_collision;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ph_ff <= 1'h0;
      snd_ff <= 1'h0;
      cr_ff <= '0;
      lim_wait_ff <= '0;
    end else begin
      wr_ph_ff <= cr_hit;
      if (wr_ph_ff) cr_ff <= i_hwdata[11:0];
      if (o_tx_go) snd_ff <= 1'h1;
      else if (i_tx_collision || i_tx_done) snd_ff <= 1'h0;
      // Cycles since a one-bit back-off began; the longest wait is one slot.
      if (coll_v && !cr_ff[10] && cr_ff[7:6] == 2'h3) lim_wait_ff <= 11'h001;
      else if (o_tx_go || o_tx_abort || lim_wait_ff == 11'(LIM_WAIT)) lim_wait_ff <= '0;
      else if (lim_wait_ff != '0) lim_wait_ff <= lim_wait_ff + 11'h001;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_resp_okay: assert property (o_hresp == 1'h0) else $error("response not OKAY");
  a_ready_run: assert property ($past(i_reset_n) |-> o_hreadyout)
    else $error("wait state seen");
  a_abort_pair: assert property (o_tx_abort == o_retry_error)
    else $error("abort and retry error differ");
  a_abort_cause: assert property (o_tx_abort |-> $past(i_tx_collision))
    else $error("abort without collision");
  a_go_pulse: assert property (o_tx_go |=> !o_tx_go) else $error("go longer than a cycle");
  a_dis_abort: assert property (coll_v && cr_ff[10] |=> o_tx_abort && !o_tx_go)
    else $error("no abort with retry disabled");
  a_lim_wait: assert property (lim_wait_ff == 11'(LIM_WAIT) |-> o_tx_go || o_tx_abort)
    else $error("one-bit back-off too long");
  a_rx_delay: assert property (o_rx_byte.valid |-> $past(i_rx_byte.valid, 7))
    else $error("output byte without input");
  a_rx_data: assert property (o_rx_byte.valid |-> o_rx_byte.data == $past(i_rx_byte.data, 7))
    else $error("byte altered");
  c_dis: cover property (coll_v && cr_ff[10]);
  c_limit: cover property (o_tx_abort && !cr_ff[10]);
  c_rx_last: cover property (o_rx_byte.valid && o_rx_byte.last);
endmodule : mfc_mac_ctrl_properties

bind mfc_mac_ctrl mfc_mac_ctrl_properties u_chk (.*);

// ---- mfc_medium_model.sv ----
// Purpose: Shared medium answering each attempt with a collision or success.
// Assumes: The bench plans how many collisions a frame meets.
// Notes: The answer comes four cycles after go, never in the go cycle.
`timescale 1ns/1ps
module mfc_medium_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_go,
  input wire logic [4:0] i_plan,
  output logic o_coll,
  output logic o_done
);
  logic [4:0] cnt_ff;
  logic [1:0] dly_ff;
  logic act_ff;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {cnt_ff, dly_ff, act_ff, o_coll, o_done} <= '0;
    end else begin
      o_coll <= 1'h0;
      o_done <= 1'h0;
      if (i_start) cnt_ff <= '0;
      if (i_go) begin
        act_ff <= 1'h1;
        dly_ff <= 2'h2;
      end else if (act_ff && dly_ff != 2'h0) begin
        dly_ff <= dly_ff - 2'h1;
      end else if (act_ff) begin
        act_ff <= 1'h0;
        o_coll <= cnt_ff < i_plan;
        o_done <= cnt_ff >= i_plan;
        cnt_ff <= cnt_ff + 5'(cnt_ff < i_plan);
      end
    end
  end
endmodule : mfc_medium_model

// ---- mac_frame_control_backoff_tb.sv ----
// Purpose: Self-checking bench of the MAC control block.
// Assumes: Registers over AHB-Lite; the medium model makes collisions.
// Notes: Back-off waits are measured from collision to the next go.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mac_frame_control_backoff_tb;
  import mfc_pkg::*;
  logic i_clk, i_reset_n, i_hsel, i_hwrite, i_tx_start, i_tx_collision, i_tx_done;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd, wdat;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic [4:0] plan;
  logic o_hreadyout, o_hresp, o_tx_go, o_tx_abort, o_retry_error, o_irq;
  mfc_byte_t i_rx_byte, o_rx_byte;
  int err_total = 0, checked = 0, cyc = 0, nc, c_at, lim, slot, nout, lastpos, aborts = 0;
  mfc_mac_ctrl DUT (.i_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hrdata, .o_hresp, .i_tx_start,
    .i_tx_collision, .i_tx_done, .o_tx_go, .o_tx_abort, .o_retry_error, .i_rx_byte,
    .o_rx_byte, .o_irq);
  mfc_medium_model u_med (.i_clk, .i_reset_n, .i_start(i_tx_start), .i_go(o_tx_go),
    .i_plan(plan), .o_coll(i_tx_collision), .o_done(i_tx_done));
  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end
  // ==========================================================================
  // Tasks
  task automatic end_sim();
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_hsel, i_hwrite, i_htrans, i_hsize} <= {1'h1, w, HTRANS_NONSEQ, HSIZE_WORD};
    i_haddr <= 32'(a);
    @(posedge i_clk);
    while (!o_hreadyout) @(posedge i_clk);
    {i_hsel, i_htrans, i_hwdata} <= {1'h0, 2'h0, d};
    @(posedge i_clk);
    while (!o_hreadyout) @(posedge i_clk);
    rd = o_hrdata;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rdr(input logic [4:0] a);
    bus(1'h0, a, 32'h0);
  endtask : rdr
  function automatic int max_r(int n, int code);
    int b;
    int lb;
    lb = code == 0 ? 10 : code == 1 ? 8 : code == 2 ? 4 : 1;
    b = n < 10 ? n : 10;
    if (lb < b) b = lb;
    return 1 << b;
  endfunction : max_r
  // Stripping keeps header and data only, so the FCS goes with the pad.
  task automatic rxchk(input logic pad, input logic blk, input logic bc, input int len);
    int exp;
    exp = (blk && bc) ? 0 : (pad && len < int'(MIN_DATA_LEN)) ? HDR_LEN + len : 64;
    wr(REG_MAC_CR, (32'(blk) << CR_BROADCAST_FRAME_CTRL_BIT) | (32'(pad) << CR_PAD_BIT));
    nout = 0;
    lastpos = -1;
    for (int i = 0; i < 64; i++) begin
      @(posedge i_clk);
      i_rx_byte <= '{1'h1, i == 63, i < DA_LEN ? (bc ? BROADCAST_FRAME_CTRL_BYTE : 8'h02) :
        i == LEN_LO_IDX ? 8'(len) : i == LEN_HI_IDX ? 8'h00 : 8'($urandom)};
    end
    @(posedge i_clk);
    i_rx_byte <= '0;
    repeat (12) @(posedge i_clk);
    `CHK(nout, exp)
    `CHK(lastpos, exp - 1)
  endtask : rxchk
  task automatic send(input logic [4:0] p, input int ab);
    int a0;
    a0 = aborts;
    @(posedge i_clk);
    plan <= p;
    i_tx_start <= 1'h1;
    @(posedge i_clk);
    i_tx_start <= 1'h0;
    // Done or abort ends this wait; a hung frame runs into the bench timeout, so it cannot pass.
    @(posedge i_clk);
    while (!(i_tx_done || o_tx_abort)) @(posedge i_clk);
    @(posedge i_clk);
    `CHK(aborts - a0, ab)
  endtask : send
  // ==========================================================================
  // Monitors
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_rx_byte.valid) begin
      if (o_rx_byte.last) lastpos = nout;
      nout++;
    end
    if (i_tx_start) nc = 0;
    if (i_tx_collision) begin
      nc++;
      c_at = cyc;
    end
    if (o_tx_go && nc > 0) begin
      `CHK((cyc - c_at - 1) % slot, 0)
      `CHK((cyc - c_at - 1) / slot < max_r(nc, lim), 1'h1)
    end
    if (o_tx_abort) aborts++;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end
  // ==========================================================================
  // Stimulus
  initial begin
    {i_hsel, i_haddr, i_htrans, i_hwrite, i_hsize, i_hwdata, i_tx_start, i_rx_byte} = '0;
    plan = '0;
    i_reset_n = 1'h0;
    lim = 0;
    slot = SLOT_CYC_100M;
    void'($urandom(32'h8fcf));
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'h1;
    rdr(REG_MAC_CR);
    `CHK(rd, CR_RESET)
    rdr(5'h14);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 4; i++) begin
      wdat = $urandom;
      wr(REG_MAC_CR, wdat);
      rdr(REG_MAC_CR);
      `CHK(rd, wdat & CR_WMASK)
    end
    rxchk(0, 0, 0, 10);
    rxchk(1, 0, 0, 10);
    rxchk(1, 0, 0, 45);
    rxchk(1, 0, 0, 46);
    rxchk(1, 0, 0, $urandom_range(0, 60));
    rxchk(1, 0, 1, 46);
    rxchk(0, 1, 1, 46);
    rdr(REG_INT_STS);
    `CHK(rd[EVT_BROADCAST_FRAME_CTRL_DROP], 1'h1)
    `CHK(o_irq, 1'h0)
    wr(REG_INT_EN, 32'h8);
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'h1)
    wr(REG_INT_STS, 32'h8);
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'h0)
    wr(REG_INT_EN, 32'h0);
    wr(REG_LINK_CFG, 32'h1);
    wr(REG_MAC_CR, 32'h400);
    send(5'h03, 1);
    rdr(REG_INT_STS);
    `CHK(rd[EVT_RETRY_ERR], 1'h1)
    for (int c = 0; c < 4; c++) begin
      lim = c;
      wr(REG_MAC_CR, 32'(c) << CR_BOLIM_LSB);
      send(5'($urandom_range(1, 4)), 0);
    end
    send(5'h0f, 0);
    send(5'h10, 1);
    wr(REG_LINK_CFG, 32'h0);
    wr(REG_INT_STS, 32'((1 << NUM_EVT) - 1));
    slot = SLOT_CYC_10M;
    send(5'h02, 0);
    rdr(REG_INT_STS);
    `CHK(rd[EVT_TX_DONE], 1'h1)
    end_sim();
  end
endmodule : mac_frame_control_backoff_tb
